// ### cat_pkg.sv
// constants, types and register map of the current adc result counter and threshold block
`default_nettype none

package cat_pkg;

  // bus and register widths
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int RES_W = 16;
  localparam int TALLY_W = 16;
  localparam int TCNT_W = 8;
  localparam int BYTE_W = 8;
  localparam int STA_W = 2;

  // register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_TALLY_LIMIT = 32'hffff_0548;
  localparam logic [ADDR_W-1:0] ADDR_TALLY = 32'hffff_054c;
  localparam logic [ADDR_W-1:0] ADDR_THRESH = 32'hffff_0550;
  localparam logic [ADDR_W-1:0] ADDR_TCL = 32'hffff_0554;
  localparam logic [ADDR_W-1:0] ADDR_TCOUNT = 32'hffff_0558;
  localparam logic [ADDR_W-1:0] ADDR_CFG = 32'hffff_0580;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 32'hffff_0584;
  localparam logic [ADDR_W-1:0] ADDR_CHAN_CTRL = 32'hffff_0588;
  localparam logic [ADDR_W-1:0] ADDR_MODE = 32'hffff_058c;

  // reset values
  localparam logic [TALLY_W-1:0] TALLY_RST = 16'h0000;
  localparam logic [TALLY_W-1:0] TALLY_LIMIT_RST = 16'h0001;
  localparam logic [RES_W-1:0] THRESH_RST = 16'h0000;
  localparam logic [TCNT_W-1:0] TCNT_RST = 8'h00;
  localparam logic [TCNT_W-1:0] TCL_RST = 8'h01;
  localparam logic [BYTE_W-1:0] CFG_RST = 8'h00;
  localparam logic [BYTE_W-1:0] CHAN_RST = 8'h00;
  localparam logic [BYTE_W-1:0] MODE_RST = 8'h00;
  localparam logic [STA_W-1:0] STA_RST = 2'h0;
  localparam logic [DATA_W-1:0] RDATA_IDLE = 32'h0000_0000;

  // counting constants
  localparam logic [TALLY_W-1:0] TALLY_STEP = 16'h0001;
  localparam logic [TCNT_W-1:0] TCNT_STEP = 8'h01;
  localparam logic [TCNT_W-1:0] TCNT_MAX = 8'hff;

  // field positions
  localparam int CFG_CNT_EN_BIT = 0;
  localparam int CFG_CMP_LSB = 3;
  localparam int CFG_CMP_MSB = 4;
  localparam int CHAN_TWOS_BIT = 0;
  localparam int STA_READY_BIT = 0;
  localparam int STA_THRESH_BIT = 1;
  localparam int RES_SIGN_BIT = 15;

  // comparator modes in the configuration register
  typedef enum logic [1:0] {
    CMP_OFF = 2'h0,
    CMP_DECR = 2'h1,
    CMP_CLEAR = 2'h2,
    CMP_RSVD = 2'h3
  } cat_cmp_mode_t;

  // one conversion result from the current-channel datapath
  typedef struct packed {
    logic valid;
    logic [RES_W-1:0] data;
  } cat_result_t;

  // one register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cat_bus_t;

endpackage : cat_pkg

`default_nettype wire

// ### cat_tally_counter.sv
// conversion tally that wraps at a programmable limit
`default_nettype none

module cat_tally_counter (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // control
  input wire logic clear_i,
  input wire logic count_en_i,
  input wire logic result_valid_i,
  input wire logic [cat_pkg::TALLY_W-1:0] limit_i,
  // state
  output logic [cat_pkg::TALLY_W-1:0] tally_o,
  output logic wrap_o
);

  logic [cat_pkg::TALLY_W-1:0] tally_ff; // running count of results
  logic [cat_pkg::TALLY_W-1:0] nxt_tally; // count after this result
  logic step; // a result is counted this cycle

  // only enabled results move the count
  assign step = result_valid_i && count_en_i;
  assign nxt_tally = tally_ff + cat_pkg::TALLY_STEP;
  // wrap event doubles as the gated conversion interrupt
  assign wrap_o = step && !clear_i && (nxt_tally == limit_i);
  assign tally_o = tally_ff;

  // reconfiguration beats a coincident result
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || clear_i) begin
      tally_ff <= cat_pkg::TALLY_RST;
    end else if (wrap_o) begin
      tally_ff <= cat_pkg::TALLY_RST;
    end else if (step) begin
      tally_ff <= nxt_tally;
    end
  end

endmodule // cat_tally_counter

`default_nettype wire

// ### cat_threshold_counter.sv
// absolute-value comparator and cumulative threshold count
`default_nettype none

module cat_threshold_counter (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // result and configuration
  input wire cat_pkg::cat_result_t result_i,
  input wire cat_pkg::cat_cmp_mode_t mode_i,
  input wire logic twos_i,
  input wire logic [cat_pkg::RES_W-1:0] threshold_i,
  input wire logic [cat_pkg::TCNT_W-1:0] limit_i,
  // state
  output logic [cat_pkg::TCNT_W-1:0] count_o,
  output logic hit_o
);

  // magnitude of a result; 0x8000 in two's complement stays 0x8000
  function automatic logic [cat_pkg::RES_W-1:0] magnitude(input logic [cat_pkg::RES_W-1:0] v, input logic twos);
    if (twos && v[cat_pkg::RES_SIGN_BIT]) begin
      magnitude = (~v) + cat_pkg::TALLY_STEP;
    end else begin
      magnitude = v;
    end
  endfunction

  logic [cat_pkg::TCNT_W-1:0] count_ff; // cumulative above-threshold count
  logic [cat_pkg::TCNT_W-1:0] nxt_count; // count after this result
  logic [cat_pkg::RES_W-1:0] thr_eff; // threshold bits that take part
  logic active; // comparator enabled by mode
  logic at_or_above; // result reached threshold

  assign active = (mode_i == cat_pkg::CMP_DECR) || (mode_i == cat_pkg::CMP_CLEAR);
  // two's complement drops the top threshold bit
  assign thr_eff = twos_i ? {1'b0, threshold_i[cat_pkg::RES_SIGN_BIT-1:0]} : threshold_i;
  assign at_or_above = magnitude(result_i.data, twos_i) >= thr_eff;

  // next count: up on reach, down or cleared below; saturates both ends
  always_comb begin
    nxt_count = count_ff;
    if (at_or_above) begin
      if (count_ff != cat_pkg::TCNT_MAX) begin
        nxt_count = count_ff + cat_pkg::TCNT_STEP;
      end
    end else if (mode_i == cat_pkg::CMP_CLEAR) begin
      nxt_count = cat_pkg::TCNT_RST;
    end else if (count_ff != cat_pkg::TCNT_RST) begin
      nxt_count = count_ff - cat_pkg::TCNT_STEP;
    end
  end

  // flag event as the updated count meets the limit
  assign hit_o = result_i.valid && active && (nxt_count == limit_i);
  assign count_o = count_ff;

  // disabled comparator parks the count at zero
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !active) begin
      count_ff <= cat_pkg::TCNT_RST;
    end else if (result_i.valid) begin
      count_ff <= nxt_count;
    end
  end

endmodule // cat_threshold_counter

`default_nettype wire

// ### cat_result_post.sv
// top of the current adc result counter and threshold block with its register file
//
// Function
// - 16-bit read-only conversion tally of results
// - tally counts only while counter enable set
// - tally equal to limit clears, keeps counting
// - writing channel control or mode clears tally
// - conversion interrupt once per limit conversions while counter enable set, else every result
// - compare result magnitude with 16-bit threshold
// - unipolar uses bits 15:0, two's uses 14:0
// - 8-bit threshold-count limit, resets to one
// - below threshold decrements or clears the count
// - flag set when count equals its limit
// - threshold flag in status raises adc interrupt
// - 8-bit threshold count rises on reaching threshold
// - 16-bit tally limit register, resets to one
// - comparator field enables and selects count behaviour
//
// Design decision made here: the strobed register port.
`default_nettype none

module cat_result_post (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // conversion results from the current-channel datapath
  input wire cat_pkg::cat_result_t result_i,
  // register bus
  input wire cat_pkg::cat_bus_t bus_i,
  output logic [cat_pkg::DATA_W-1:0] rdata_o,
  // interrupt request
  output logic irq_o
);

  // register map: one 32-bit word per register, narrow registers in the low bits
  //   tally limit: read/write, 16 bits, resets to one
  //   conversion tally: read only, 16 bits
  //   magnitude threshold: read/write, 16 bits
  //   threshold count limit: read/write, 8 bits, resets to one
  //   threshold count: read only, 8 bits
  //   adc configuration: read/write, 8 bits
  //   adc status: write one to clear, bit 0 result ready, bit 1 threshold reached
  //   current channel control: read/write, 8 bits
  //   adc mode: read/write, 8 bits
  // upper bits read as zero and extra write bits are dropped
  //
  // configuration: bit 0 enables the result counter, bits 4:3 pick the comparator,
  //   00 off, 01 decrement below threshold, 10 clear below threshold, 11 off
  // channel control: bit 0 set for two's complement results, clear for unipolar
  //
  // timing: a result taken at edge n moves both counters and the status at edge n,
  //   and the interrupt level changes at that same edge; a read strobe taken at
  //   edge n shows its data for the one cycle after edge n, zero otherwise
  //
  // limitations: the accumulator, the other channels and calibration live elsewhere;
  //   the threshold count saturates at both ends rather than rolling over; the
  //   threshold flag may be raised again while the count sits at its limit; a result
  //   that meets a reconfiguring write in the same cycle is not counted in the tally
  // the block never stalls the bus, so a read costs exactly one cycle of latency

  // address match helper, shared by the write and read decoders
  function automatic logic hit(input logic [cat_pkg::ADDR_W-1:0] a, input logic [cat_pkg::ADDR_W-1:0] ref_a);
    hit = (a == ref_a);
  endfunction

  // software registers
  logic [cat_pkg::TALLY_W-1:0] tally_limit_ff; // conversions per wrap
  logic [cat_pkg::RES_W-1:0] threshold_ff; // magnitude threshold
  logic [cat_pkg::TCNT_W-1:0] tcl_ff; // threshold count limit
  logic [cat_pkg::BYTE_W-1:0] cfg_ff; // adc configuration
  logic [cat_pkg::BYTE_W-1:0] chan_ff; // current channel control
  logic [cat_pkg::BYTE_W-1:0] mode_ff; // adc mode register
  logic [cat_pkg::STA_W-1:0] status_ff; // sticky status bits
  logic [cat_pkg::STA_W-1:0] nxt_status; // status after set and clear

  // output registers
  logic [cat_pkg::DATA_W-1:0] rdata_ff; // read data, one cycle after strobe
  logic [cat_pkg::DATA_W-1:0] nxt_rdata; // selected read value
  logic irq_ff; // interrupt request level

  // decoded write strobes
  logic wr_limit; // tally limit write
  logic wr_thresh; // threshold write
  logic wr_tcl; // threshold count limit write
  logic wr_cfg; // configuration write
  logic wr_status; // status clear write
  logic wr_chan; // channel control write
  logic wr_mode; // mode write
  logic reconfig; // channel reconfigured this cycle

  // block state
  logic [cat_pkg::TALLY_W-1:0] tally; // conversion tally
  logic [cat_pkg::TCNT_W-1:0] tcount; // threshold count
  logic tally_wrap; // gated conversion event
  logic thresh_hit; // threshold count reached its limit
  logic ready_evt; // event that sets the ready bit
  logic count_en; // result counter enable
  cat_pkg::cat_cmp_mode_t cmp_mode; // comparator mode

  // write decode: a plain if chain, one register per address
  always_comb begin
    wr_limit = 1'b0;
    wr_thresh = 1'b0;
    wr_tcl = 1'b0;
    wr_cfg = 1'b0;
    wr_status = 1'b0;
    wr_chan = 1'b0;
    wr_mode = 1'b0;
    // only one strobe is high per cycle, so a write never competes with a read
    if (bus_i.wr) begin
      if (hit(bus_i.addr, cat_pkg::ADDR_TALLY_LIMIT)) begin
        wr_limit = 1'b1;
      end else if (hit(bus_i.addr, cat_pkg::ADDR_THRESH)) begin
        wr_thresh = 1'b1;
      end else if (hit(bus_i.addr, cat_pkg::ADDR_TCL)) begin
        wr_tcl = 1'b1;
      end else if (hit(bus_i.addr, cat_pkg::ADDR_CFG)) begin
        wr_cfg = 1'b1;
      end else if (hit(bus_i.addr, cat_pkg::ADDR_STATUS)) begin
        wr_status = 1'b1;
      end else if (hit(bus_i.addr, cat_pkg::ADDR_CHAN_CTRL)) begin
        wr_chan = 1'b1;
      end else if (hit(bus_i.addr, cat_pkg::ADDR_MODE)) begin
        wr_mode = 1'b1;
      end
      // writes to the read-only counts or unmapped addresses are dropped
    end
  end

  // any channel control or mode write counts as a reconfiguration, even with an unchanged value
  // the mode register steers nothing else here; only its write side effect matters
  assign reconfig = wr_chan || wr_mode;

  // configuration fields that steer the counters
  assign count_en = cfg_ff[cat_pkg::CFG_CNT_EN_BIT];
  assign cmp_mode = cat_pkg::cat_cmp_mode_t'(cfg_ff[cat_pkg::CFG_CMP_MSB:cat_pkg::CFG_CMP_LSB]);

  // tally limit register
  // a limit of zero matches only when the tally rolls over from 0xffff, once per 65536 counted results
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tally_limit_ff <= cat_pkg::TALLY_LIMIT_RST;
    end else if (wr_limit) begin
      tally_limit_ff <= bus_i.wdata[cat_pkg::TALLY_W-1:0];
    end
  end

  // threshold register
  // the full word is kept; the two's complement view drops bit 15 downstream
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      threshold_ff <= cat_pkg::THRESH_RST;
    end else if (wr_thresh) begin
      threshold_ff <= bus_i.wdata[cat_pkg::RES_W-1:0];
    end
  end

  // threshold count limit register
  // a limit of zero is met whenever a below-threshold result leaves the count at zero
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tcl_ff <= cat_pkg::TCL_RST;
    end else if (wr_tcl) begin
      tcl_ff <= bus_i.wdata[cat_pkg::TCNT_W-1:0];
    end
  end

  // configuration register
  // bit 0 enables the tally, bits 4:3 pick the comparator mode
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cfg_ff <= cat_pkg::CFG_RST;
    end else if (wr_cfg) begin
      cfg_ff <= bus_i.wdata[cat_pkg::BYTE_W-1:0];
    end
  end

  // channel control register; bit 0 picks two's complement results
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      chan_ff <= cat_pkg::CHAN_RST;
    end else if (wr_chan) begin
      chan_ff <= bus_i.wdata[cat_pkg::BYTE_W-1:0];
    end
  end

  // mode register; held only for read-back here
  // a write of the same value still clears the tally
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      mode_ff <= cat_pkg::MODE_RST;
    end else if (wr_mode) begin
      mode_ff <= bus_i.wdata[cat_pkg::BYTE_W-1:0];
    end
  end

  // conversion tally with wrap at the limit
  cat_tally_counter u_tally (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .clear_i(reconfig),
    .count_en_i(count_en),
    .result_valid_i(result_i.valid),
    .limit_i(tally_limit_ff),
    .tally_o(tally),
    .wrap_o(tally_wrap)
  );

  // magnitude comparator and threshold count
  // kept apart from the tally so that each counter can be reasoned about alone
  cat_threshold_counter u_thresh (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .result_i(result_i),
    .mode_i(cmp_mode),
    .twos_i(chan_ff[cat_pkg::CHAN_TWOS_BIT]),
    .threshold_i(threshold_ff),
    .limit_i(tcl_ff),
    .count_o(tcount),
    .hit_o(thresh_hit)
  );

  // with the counter off every result is reported, otherwise only wraps
  // the ready bit is the gated conversion interrupt of this channel
  assign ready_evt = count_en ? tally_wrap : result_i.valid;

  // status: write one to clear, a coincident event keeps its bit set
  // the clear is applied first so that the set lines below override it
  always_comb begin
    nxt_status = status_ff;
    if (wr_status) begin
      nxt_status = status_ff & ~bus_i.wdata[cat_pkg::STA_W-1:0];
    end
    if (ready_evt) begin
      nxt_status[cat_pkg::STA_READY_BIT] = 1'b1;
    end
    if (thresh_hit) begin
      nxt_status[cat_pkg::STA_THRESH_BIT] = 1'b1;
    end
  end

  // status register
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      status_ff <= cat_pkg::STA_RST;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // interrupt follows the status bits on the same edge, no extra lag
  // there is no separate interrupt enable: the level is the or of the status bits
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |nxt_status;
    end
  end

  // read select; unmapped addresses read as zero
  // reads have no side effects, so status bits leave only by a write
  always_comb begin
    nxt_rdata = cat_pkg::RDATA_IDLE;
    if (hit(bus_i.addr, cat_pkg::ADDR_TALLY_LIMIT)) begin
      nxt_rdata = cat_pkg::DATA_W'(tally_limit_ff);
    end else if (hit(bus_i.addr, cat_pkg::ADDR_TALLY)) begin
      nxt_rdata = cat_pkg::DATA_W'(tally);
    end else if (hit(bus_i.addr, cat_pkg::ADDR_THRESH)) begin
      nxt_rdata = cat_pkg::DATA_W'(threshold_ff);
    end else if (hit(bus_i.addr, cat_pkg::ADDR_TCL)) begin
      nxt_rdata = cat_pkg::DATA_W'(tcl_ff);
    end else if (hit(bus_i.addr, cat_pkg::ADDR_TCOUNT)) begin
      nxt_rdata = cat_pkg::DATA_W'(tcount);
    end else if (hit(bus_i.addr, cat_pkg::ADDR_CFG)) begin
      nxt_rdata = cat_pkg::DATA_W'(cfg_ff);
    end else if (hit(bus_i.addr, cat_pkg::ADDR_STATUS)) begin
      nxt_rdata = cat_pkg::DATA_W'(status_ff);
    end else if (hit(bus_i.addr, cat_pkg::ADDR_CHAN_CTRL)) begin
      nxt_rdata = cat_pkg::DATA_W'(chan_ff);
    end else if (hit(bus_i.addr, cat_pkg::ADDR_MODE)) begin
      nxt_rdata = cat_pkg::DATA_W'(mode_ff);
    end
  end

  // read data stand for exactly the cycle after the strobe, else zero
  // holding stale data would let one read alias into the next idle cycle
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rdata_ff <= cat_pkg::RDATA_IDLE;
    end else if (bus_i.rd) begin
      rdata_ff <= nxt_rdata;
    end else begin
      rdata_ff <= cat_pkg::RDATA_IDLE;
    end
  end

  // ports straight from flip-flops
  assign rdata_o = rdata_ff;
  assign irq_o = irq_ff;

endmodule // cat_result_post

`default_nettype wire

// ### cat_adc_source.sv
// behavioural current-channel datapath that hands conversion results to the block
`default_nettype none

module cat_adc_source (
  // clock
  input wire logic ref_clk_i,
  // request from the bench
  input wire logic send_i,
  input wire logic [cat_pkg::RES_W-1:0] data_i,
  // result towards the block
  output var cat_pkg::cat_result_t result_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle at time zero so the block never sees an unknown strobe
  initial result_o = '0;

  // one-cycle valid per request; between results the data lines toggle
  // so a block that samples stale data cannot pass by luck
  always @(posedge ref_clk_i) begin
    result_o.valid <= send_i;
    result_o.data <= send_i ? data_i : ~result_o.data;
  end
endmodule // cat_adc_source

`default_nettype wire

// ### cat_result_post_chk.sv
// port-level assertions for the result counter and threshold block
`default_nettype none

module cat_result_post_chk (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // watched ports
  input wire cat_pkg::cat_result_t result_i,
  input wire cat_pkg::cat_bus_t bus_i,
  input wire logic [cat_pkg::DATA_W-1:0] rdata_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // one clock domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  // read data and interrupt are quiet right after reset
  a_reset_quiet: assert property ($past(reset_i) |-> rdata_o == 32'h0000_0000 && !irq_o)
    else $error("outputs not quiet after reset");
  // read data only in the cycle after a read strobe
  a_rdata_idle: assert property (!$past(bus_i.rd) |-> rdata_o == 32'h0000_0000)
    else $error("read data without a read");
  // tally is sixteen bits wide
  a_tally_width: assert property ($past(bus_i.rd && bus_i.addr == cat_pkg::ADDR_TALLY)
      |-> rdata_o[31:16] == 16'h0000)
    else $error("tally wider than 16 bits");
  // tally limit is sixteen bits wide
  a_limit_width: assert property ($past(bus_i.rd && bus_i.addr == cat_pkg::ADDR_TALLY_LIMIT)
      |-> rdata_o[31:16] == 16'h0000)
    else $error("tally limit wider than 16 bits");
  // threshold count limit is eight bits wide
  a_tcl_width: assert property ($past(bus_i.rd && bus_i.addr == cat_pkg::ADDR_TCL)
      |-> rdata_o[31:8] == 24'h00_0000)
    else $error("count limit wider than 8 bits");
  // threshold count is eight bits wide
  a_count_width: assert property ($past(bus_i.rd && bus_i.addr == cat_pkg::ADDR_TCOUNT)
      |-> rdata_o[31:8] == 24'h00_0000)
    else $error("threshold count wider than 8 bits");
  // reconfiguring the channel empties the tally at once
  a_reconf_clear: assert property ($past(bus_i.wr && (bus_i.addr == cat_pkg::ADDR_CHAN_CTRL ||
      bus_i.addr == cat_pkg::ADDR_MODE)) && bus_i.rd && bus_i.addr == cat_pkg::ADDR_TALLY
      |=> rdata_o == 32'h0000_0000)
    else $error("tally not cleared by reconfiguration");
  // an interrupt only rises after a conversion result
  a_irq_cause: assert property ($rose(irq_o) |-> $past(result_i.valid) || $past(result_i.valid, 2))
    else $error("interrupt without a result");
  // an interrupt only falls after a register write
  a_irq_sticky: assert property ($fell(irq_o) |-> $past(bus_i.wr) || $past(bus_i.wr, 2))
    else $error("interrupt dropped without a write");
endmodule // cat_result_post_chk

`default_nettype wire

// ### test_cat_result_post.sv
// self-checking bench for the result counter and threshold block
`default_nettype none

module test_cat_result_post;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic send = 1'b0; // request to the datapath model
  logic [15:0] sdata = 16'h0000;
  cat_pkg::cat_result_t result;
  cat_pkg::cat_bus_t bus = '0;
  logic [31:0] rdata;
  logic irq;
  int fails = 0;
  int n_checks = 0;
  // reference state kept with plain integers
  int m_tally = 0, m_lim = 1, m_en = 0, m_sta = 0, m_tc = 0, m_tcl = 1, m_th = 0, m_mode = 0, m_twos = 0;

  // 10 MHz clock
  always #50 ref_clk_i = ~ref_clk_i;

  cat_adc_source u_cat_adc_source (.ref_clk_i(ref_clk_i), .send_i(send), .data_i(sdata), .result_o(result));
  cat_result_post u_cat_result_post (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .result_i(result), .bus_i(bus),
    .rdata_o(rdata), .irq_o(irq));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one write cycle, then the reference follows it
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk_i);
    bus.wr <= 1'b0;
    case (a)
      cat_pkg::ADDR_TALLY_LIMIT: m_lim = d[15:0];
      cat_pkg::ADDR_THRESH: m_th = d[15:0];
      cat_pkg::ADDR_TCL: m_tcl = d[7:0];
      cat_pkg::ADDR_CFG: begin
        m_en = d[0];
        m_mode = d[4:3];
      end
      cat_pkg::ADDR_STATUS: m_sta = m_sta & ~int'(d[1:0]);
      cat_pkg::ADDR_CHAN_CTRL: begin
        m_twos = d[0];
        m_tally = 0;
      end
      cat_pkg::ADDR_MODE: m_tally = 0;
      default: ;
    endcase
  endtask

  // one read cycle; data is looked at in the single cycle it stands
  task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
    @(posedge ref_clk_i);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge ref_clk_i);
    bus.rd <= 1'b0;
    @(negedge ref_clk_i);
    chk(rdata, exp, what);
  endtask

  // one conversion result through the datapath model, reference updated at the taking edge
  task automatic res(input logic [15:0] d);
    int mag;
    int th;
    @(posedge ref_clk_i);
    send <= 1'b1;
    sdata <= d;
    @(posedge ref_clk_i);
    send <= 1'b0;
    @(posedge ref_clk_i);
    if (m_en) begin
      m_tally = (m_tally + 1) & 32'h0000_ffff;
      if (m_tally == m_lim) begin
        m_tally = 0;
        m_sta |= 1;
      end
    end else begin
      m_sta |= 1;
    end
    mag = (m_twos && d[15]) ? 65536 - int'(d) : int'(d);
    th = m_twos ? (m_th & 32'h0000_7fff) : m_th;
    if (m_mode == 0 || m_mode == 3) begin
      m_tc = 0;
    end else begin
      if (mag >= th) m_tc = (m_tc == 255) ? 255 : m_tc + 1;
      else if (m_mode == 1) m_tc = (m_tc == 0) ? 0 : m_tc - 1;
      else m_tc = 0;
      if (m_tc == m_tcl) m_sta |= 2;
    end
    @(negedge ref_clk_i);
    chk(32'(irq), 32'(m_sta != 0), "irq after result");
  endtask

  // write then read the tally with no gap, so a clear by the write is seen at once
  task automatic wr_then_tally(input logic [31:0] a, input logic [31:0] d, input string what);
    @(posedge ref_clk_i);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk_i);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: cat_pkg::ADDR_TALLY, wdata: 32'h0000_0000};
    m_tally = 0;
    if (a == cat_pkg::ADDR_CHAN_CTRL) m_twos = d[0];
    @(posedge ref_clk_i);
    bus.rd <= 1'b0;
    @(negedge ref_clk_i);
    chk(rdata, 32'h0000_0000, what);
  endtask

  // result, then every observable count, then clear status and see the interrupt drop
  task automatic step(input logic [15:0] d);
    res(d);
    rd(cat_pkg::ADDR_TALLY, 32'(m_tally), "tally");
    rd(cat_pkg::ADDR_TCOUNT, 32'(m_tc), "threshold count");
    rd(cat_pkg::ADDR_STATUS, 32'(m_sta), "status");
    wr(cat_pkg::ADDR_STATUS, 32'h0000_0003);
    @(posedge ref_clk_i);
    @(negedge ref_clk_i);
    chk(32'(irq), 32'(m_sta != 0), "irq after clear");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog far beyond the thousand-odd cycles the tests need
  initial begin
    #4_000_000;
    fails++;
    print_verdict();
  end

  initial begin
    void'($urandom(63));
    repeat (4) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    // reset values, unmapped address
    rd(cat_pkg::ADDR_TALLY_LIMIT, 32'h0000_0001, "tally limit reset");
    rd(cat_pkg::ADDR_TALLY, 32'h0000_0000, "tally reset");
    rd(cat_pkg::ADDR_THRESH, 32'h0000_0000, "threshold reset");
    rd(cat_pkg::ADDR_TCL, 32'h0000_0001, "count limit reset");
    rd(cat_pkg::ADDR_TCOUNT, 32'h0000_0000, "count reset");
    rd(32'hffff_0560, 32'h0000_0000, "unmapped");
    // access kinds and widths
    wr(cat_pkg::ADDR_TALLY_LIMIT, 32'hffff_ffff);
    rd(cat_pkg::ADDR_TALLY_LIMIT, 32'h0000_ffff, "tally limit rw");
    wr(cat_pkg::ADDR_THRESH, 32'hffff_ffff);
    rd(cat_pkg::ADDR_THRESH, 32'h0000_ffff, "threshold rw");
    wr(cat_pkg::ADDR_TCL, 32'hffff_ffff);
    rd(cat_pkg::ADDR_TCL, 32'h0000_00ff, "count limit rw");
    wr(cat_pkg::ADDR_TALLY, 32'h0000_1234);
    rd(cat_pkg::ADDR_TALLY, 32'h0000_0000, "tally read only");
    // wrap at limit three, interrupt once per three results
    wr(cat_pkg::ADDR_TCL, 32'h0000_0001);
    wr(cat_pkg::ADDR_TALLY_LIMIT, 32'h0000_0003);
    wr(cat_pkg::ADDR_CFG, 32'h0000_0001);
    repeat (7) step(16'($urandom));
    // counter disabled holds the tally
    wr(cat_pkg::ADDR_CFG, 32'h0000_0000);
    repeat (2) step(16'($urandom));
    // reconfiguration clears a non-zero tally, read with no gap after the write
    wr(cat_pkg::ADDR_CFG, 32'h0000_0001);
    step(16'h0001);
    wr_then_tally(cat_pkg::ADDR_CHAN_CTRL, 32'h0000_0000, "tally after control write");
    step(16'h0002);
    wr_then_tally(cat_pkg::ADDR_MODE, 32'h0000_0005, "tally after mode write");
    // every comparator mode in both result codings with random thresholds
    for (int md = 0; md < 4; md++) begin
      for (int tw = 0; tw < 2; tw++) begin
        wr(cat_pkg::ADDR_CHAN_CTRL, 32'(tw));
        wr(cat_pkg::ADDR_CFG, 32'((md << 3) | 1));
        wr(cat_pkg::ADDR_THRESH, $urandom);
        wr(cat_pkg::ADDR_TCL, 32'($urandom_range(4, 1)));
        repeat (10) step(16'($urandom));
      end
    end
    print_verdict();
  end
endmodule // test_cat_result_post

bind cat_result_post cat_result_post_chk u_cat_result_post_chk (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
  .result_i(result_i), .bus_i(bus_i), .rdata_o(rdata_o), .irq_o(irq_o));

`default_nettype wire
